// ===== hdl/ppw_regs.vh
// Constants for the protected page write host controller
`ifndef PPW_REGS_VH
`define PPW_REGS_VH
`define PPW_CLK_MHZ 125
`define PPW_PAGE_BYTES 64
`define PPW_ADDR_W 13
`define PPW_PAGE_LSB 6
// Protection command sequence: addresses and data
`define PPW_CMD0_ADDR 13'h1555
`define PPW_CMD0_DATA 8'hAA
`define PPW_CMD1_ADDR 13'h0AAA
`define PPW_CMD1_DATA 8'h55
`define PPW_CMD2_ADDR 13'h1555
`define PPW_CMD2_DATA 8'hA0
// Strobe timing in ns and derived cycles
`define PPW_T_WP_NS 200
`define PPW_WP_CYC ((`PPW_T_WP_NS * `PPW_CLK_MHZ + 999) / 1000)
`define PPW_T_WPH_NS 100
`define PPW_WPH_CYC ((`PPW_T_WPH_NS * `PPW_CLK_MHZ + 999) / 1000)
`define PPW_T_ACC_NS 200
`define PPW_ACC_CYC ((`PPW_T_ACC_NS * `PPW_CLK_MHZ + 999) / 1000)
`define PPW_T_OEHP_NS 150
`define PPW_OEHP_CYC ((`PPW_T_OEHP_NS * `PPW_CLK_MHZ + 999) / 1000)
// Byte load window in us, longest time, rounded down
`define PPW_T_BLC_US 100
`define PPW_BLC_CYC (`PPW_T_BLC_US * `PPW_CLK_MHZ)
// Internal program time in ms
`define PPW_T_WC_MS 10
`define PPW_WC_CYC (`PPW_T_WC_MS * 1000 * `PPW_CLK_MHZ)
`endif

// ===== hdl/ppw_fifo.v
// Data FIFO between the user side and the page loader
`timescale 1ns/1ps
module ppw_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] cnt_r;
  wire do_wr;
  wire do_rd;
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rd_ptr_r];
  assign level = cnt_r;
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always @(posedge clk) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ===== hdl/ppw_timer.v
// Loadable down counter with a done flag
`timescale 1ns/1ps
module ppw_timer #(
  parameter W = 24
) (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [W-1:0] value,
  output wire done
);
  reg [W-1:0] cnt_r;
  assign done = (cnt_r == {W{1'b0}});
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= {W{1'b0}};
    end else if (load) begin
      cnt_r <= value;
    end else if (!done) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// ===== hdl/ppw_host.v
// Host controller that writes protected pages and polls completion
`timescale 1ns/1ps
`include "ppw_regs.vh"
// What this block does
// - Protection sequence opens every write
// - One to sixty-four bytes per page
// - Same page bits on every data strobe fall
// - Exact command addresses on first three
// - Output enable high during every write
// - Next byte within the load window while the stream keeps up; a lapse leads to polling and a fresh sequence
// - Output enable pulse clocks each status read
// - Only status line change is meaningful
// - Polling address held constant
module ppw_host #(
  parameter FIFO_DEPTH = 32,
  parameter BLC_CYC = `PPW_BLC_CYC,
  parameter WC_CYC = `PPW_WC_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [`PPW_ADDR_W-1:0] start_addr,
  input wire [6:0] byte_count,
  output wire busy,
  output reg done_r,
  output reg timeout_r,
  input wire [7:0] wr_data,
  input wire wr_valid,
  output wire wr_ready,
  output reg [`PPW_ADDR_W-1:0] mem_addr_r,
  output reg mem_ce_n_r,
  output reg mem_oe_n_r,
  output reg mem_we_n_r,
  output reg [7:0] mem_dq_out_r,
  output reg mem_dq_oe_r,
  input wire [7:0] mem_dq_in
);
  localparam ST_IDLE = 7'h01;
  localparam ST_FILL = 7'h02;
  localparam ST_SETUP = 7'h04;
  localparam ST_LOW = 7'h08;
  localparam ST_HIGH = 7'h10;
  localparam ST_POLL = 7'h20;
  localparam ST_CMP = 7'h40;
  localparam TW = 24;
  localparam [TW-1:0] WP_CYC = `PPW_WP_CYC;
  localparam [TW-1:0] WPH_CYC = `PPW_WPH_CYC;
  localparam [TW-1:0] ACC_CYC = `PPW_ACC_CYC;
  localparam [TW-1:0] OEHP_CYC = `PPW_OEHP_CYC;
  localparam [TW-1:0] BLC_LIM = BLC_CYC;
  localparam [TW-1:0] WC_LIM = WC_CYC;

  reg [6:0] state_r;
  reg [6:0] state_nxt;
  reg [1:0] cmd_idx_r;
  reg [6:0] left_r;
  reg [5:0] col_r;
  reg [`PPW_ADDR_W-1:0] base_r;
  reg have_prev_r;
  reg [7:0] prev_r;
  reg tload;
  reg [TW-1:0] tval;
  reg wdog_load;
  reg pop;
  wire tdone;
  wire wdog_done;
  wire [7:0] f_data;
  wire f_valid;
  wire [5:0] f_level;
  wire in_cmd;

  ppw_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(5)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(pop),
    .level(f_level)
  );
  ppw_timer #(.W(TW)) u_step (
    .clk(clk),
    .rst_n(rst_n),
    .load(tload),
    .value(tval),
    .done(tdone)
  );
  ppw_timer #(.W(TW)) u_wdog (
    .clk(clk),
    .rst_n(rst_n),
    .load(wdog_load),
    .value(WC_LIM),
    .done(wdog_done)
  );

  assign busy = (state_r != ST_IDLE);
  assign in_cmd = (cmd_idx_r != 2'd3);

  // Next strobe address and data
  function [`PPW_ADDR_W+7:0] cmd_word;
    input [1:0] idx;
    begin
      case (idx)
        2'd0: cmd_word = {`PPW_CMD0_ADDR, `PPW_CMD0_DATA};
        2'd1: cmd_word = {`PPW_CMD1_ADDR, `PPW_CMD1_DATA};
        default: cmd_word = {`PPW_CMD2_ADDR, `PPW_CMD2_DATA};
      endcase
    end
  endfunction

  always @* begin
    state_nxt = state_r;
    tload = 1'b0;
    tval = {TW{1'b0}};
    wdog_load = 1'b0;
    pop = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (start && byte_count != 7'd0 && byte_count <= `PPW_PAGE_BYTES) begin
          state_nxt = ST_FILL;
        end
      end
      ST_FILL: begin
        // Whole page, or 32 bytes if larger, buffered first; a stalled stream can still let the load window lapse
        if ({1'b0, f_level} >= left_r || f_level == 6'd32) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (in_cmd || f_valid) begin
          state_nxt = ST_LOW;
          tload = 1'b1;
          tval = WP_CYC;
        end else if (tdone) begin
          // Window lapsed: device now programs what was loaded so far
          state_nxt = ST_POLL;
          tload = 1'b1;
          tval = ACC_CYC;
          wdog_load = 1'b1;
        end
      end
      ST_LOW: begin
        if (tdone) begin
          state_nxt = ST_HIGH;
          tload = 1'b1;
          tval = WPH_CYC;
          pop = !in_cmd;
        end
      end
      ST_HIGH: begin
        if (tdone) begin
          if (in_cmd || left_r != 7'd0) begin
            state_nxt = ST_SETUP;
            tload = 1'b1;
            tval = BLC_LIM - WP_CYC - WPH_CYC;
          end else begin
            state_nxt = ST_POLL;
            tload = 1'b1;
            tval = ACC_CYC;
            wdog_load = 1'b1;
          end
        end
      end
      ST_POLL: begin
        if (tdone) begin
          state_nxt = ST_CMP;
          tload = 1'b1;
          tval = OEHP_CYC;
        end
      end
      ST_CMP: begin
        if (tdone) begin
          state_nxt = ST_POLL;
          tload = 1'b1;
          tval = ACC_CYC;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cmd_idx_r <= 2'd0;
      left_r <= 7'd0;
      col_r <= 6'd0;
      base_r <= {`PPW_ADDR_W{1'b0}};
      have_prev_r <= 1'b0;
      prev_r <= 8'h00;
      done_r <= 1'b0;
      timeout_r <= 1'b0;
      mem_addr_r <= {`PPW_ADDR_W{1'b0}};
      mem_ce_n_r <= 1'b1;
      mem_oe_n_r <= 1'b1;
      mem_we_n_r <= 1'b1;
      mem_dq_out_r <= 8'h00;
      mem_dq_oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (state_nxt == ST_FILL) begin
            cmd_idx_r <= 2'd0;
            left_r <= byte_count;
            base_r <= start_addr;
            col_r <= start_addr[5:0];
            timeout_r <= 1'b0;
          end
        end
        ST_SETUP: begin
          if (state_nxt == ST_LOW) begin
            // Output enable held high across the write strobe
            mem_oe_n_r <= 1'b1;
            mem_ce_n_r <= 1'b0;
            mem_we_n_r <= 1'b0;
            mem_dq_oe_r <= 1'b1;
            if (in_cmd) begin
              {mem_addr_r, mem_dq_out_r} <= cmd_word(cmd_idx_r);
            end else begin
              mem_addr_r <= {base_r[`PPW_ADDR_W-1:`PPW_PAGE_LSB], col_r};
              mem_dq_out_r <= f_data;
            end
          end else if (state_nxt == ST_POLL) begin
            // Wait out the program cycle before loading the rest
            have_prev_r <= 1'b0;
            mem_addr_r <= {base_r[`PPW_ADDR_W-1:`PPW_PAGE_LSB], col_r - 6'd1};
            mem_ce_n_r <= 1'b0;
            mem_oe_n_r <= 1'b0;
          end
        end
        ST_LOW: begin
          if (tdone) begin
            mem_we_n_r <= 1'b1;
            mem_ce_n_r <= 1'b1;
            if (in_cmd) begin
              cmd_idx_r <= cmd_idx_r + 2'd1;
            end else begin
              left_r <= left_r - 7'd1;
              col_r <= col_r + 6'd1;
            end
          end
        end
        ST_HIGH: begin
          mem_dq_oe_r <= 1'b0;
          if (tdone && state_nxt == ST_POLL) begin
            have_prev_r <= 1'b0;
            // Fixed polling address for every status read
            mem_addr_r <= {base_r[`PPW_ADDR_W-1:`PPW_PAGE_LSB], col_r - 6'd1};
            mem_ce_n_r <= 1'b0;
            mem_oe_n_r <= 1'b0;
          end
        end
        ST_POLL: begin
          if (tdone) begin
            mem_oe_n_r <= 1'b1;
            have_prev_r <= 1'b1;
            prev_r <= mem_dq_in;
            // Two reads in a row with equal bit 6 mean the cycle has ended
            if (have_prev_r && prev_r[6] == mem_dq_in[6]) begin
              mem_ce_n_r <= 1'b1;
              if (left_r != 7'd0) begin
                // Device relocked; rest of the page needs a fresh sequence
                state_r <= ST_FILL;
                cmd_idx_r <= 2'd0;
              end else begin
                state_r <= ST_IDLE;
                done_r <= 1'b1;
              end
            end else if (wdog_done) begin
              state_r <= ST_IDLE;
              mem_ce_n_r <= 1'b1;
              done_r <= 1'b1;
              timeout_r <= 1'b1;
            end
          end
        end
        ST_CMP: begin
          if (tdone) begin
            mem_oe_n_r <= 1'b0;
          end
        end
        default: begin
          mem_ce_n_r <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ===== verif/ppw_host_props.sv
// Pin-level assertions for the page write host
`timescale 1ns/1ps
`include "ppw_regs.vh"
module ppw_host_props (
  input wire clk,
  input wire rst_n,
  input wire busy,
  input wire done_r,
  input wire [12:0] mem_addr_r,
  input wire mem_ce_n_r,
  input wire mem_oe_n_r,
  input wire mem_we_n_r,
  input wire [7:0] mem_dq_out_r,
  input wire mem_dq_oe_r
);
  reg [6:0] wc_r;
  reg [6:0] pg_r;
  reg [12:0] pa_r;
  reg ps_r;
  // Strobe count, page and poll address of the current write
  always @(posedge clk) begin
    if (!rst_n || !busy) begin
      wc_r <= 7'h00;
      ps_r <= 1'b0;
    end else begin
      if ($fell(mem_we_n_r)) begin
        wc_r <= wc_r + 7'h01;
        ps_r <= 1'b0;
      end
      if ($fell(mem_we_n_r) && wc_r == 7'h03) pg_r <= mem_addr_r[12:6];
      // Status reads end a load; the next write opens a new sequence
      if ($fell(mem_oe_n_r)) begin
        wc_r <= 7'h00;
        ps_r <= 1'b1;
        pa_r <= mem_addr_r;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cmd_zero: assert property ($fell(mem_we_n_r) && wc_r == 7'h00
    |-> mem_addr_r == `PPW_CMD0_ADDR && mem_dq_out_r == `PPW_CMD0_DATA) else $error("bad first command");
  a_cmd_one: assert property ($fell(mem_we_n_r) && wc_r == 7'h01
    |-> mem_addr_r == `PPW_CMD1_ADDR && mem_dq_out_r == `PPW_CMD1_DATA) else $error("bad second command");
  a_cmd_two: assert property ($fell(mem_we_n_r) && wc_r == 7'h02
    |-> mem_addr_r == `PPW_CMD2_ADDR && mem_dq_out_r == `PPW_CMD2_DATA) else $error("bad third command");
  a_page_same: assert property ($fell(mem_we_n_r) && wc_r > 7'h03
    |-> mem_addr_r[12:6] == pg_r) else $error("page bits changed");
  a_oe_write: assert property (!mem_we_n_r |-> mem_oe_n_r && !mem_ce_n_r) else $error("oe low in write");
  a_poll_addr: assert property ($fell(mem_oe_n_r) && ps_r |-> mem_addr_r == pa_r) else $error("poll addr moved");
  a_poll_read: assert property ($fell(mem_oe_n_r)
    |-> !mem_ce_n_r && mem_we_n_r && !mem_dq_oe_r) else $error("bad status read");
  a_done_idle: assert property (done_r |=> !done_r && !busy && mem_ce_n_r) else $error("done not final");
endmodule
bind ppw_host ppw_host_props chk_i (.clk(clk), .rst_n(rst_n), .busy(busy), .done_r(done_r),
  .mem_addr_r(mem_addr_r), .mem_ce_n_r(mem_ce_n_r), .mem_oe_n_r(mem_oe_n_r), .mem_we_n_r(mem_we_n_r),
  .mem_dq_out_r(mem_dq_out_r), .mem_dq_oe_r(mem_dq_oe_r));

// ===== verif/ppw_mem_model.sv
// Behavioural protected page memory seen at the host pins
`timescale 1ns/1ps
`include "ppw_regs.vh"
module ppw_mem_model #(
  parameter BLC = 150,
  parameter WC = 600
) (
  input wire clk,
  input wire slow,
  input wire [12:0] a,
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire [7:0] hd,
  input wire hoe,
  output wire [7:0] dq
);
  reg [7:0] mem [0:8191];
  reg [7:0] pb [0:63];
  reg [63:0] pm;
  reg [12:0] la;
  reg [6:0] pg;
  reg [7:0] ld, rd, lst;
  reg [1:0] sq;
  reg wp, rp, lo, pr, tg;
  integer t, i;
  wire w = !ce_n && !we_n && oe_n;
  wire r = !ce_n && !oe_n && we_n;
  // Released bus shows the inverse of the last value
  assign dq = r ? rd : hoe ? hd : ~lst;
  initial begin
    for (i = 0; i < 8192; i = i + 1) mem[i] = 8'hFF;
    {pm, sq, wp, rp, lo, pr, tg, t, lst, rd} = 0;
  end
  always @(negedge clk) begin
    t = t + 1;
    if (w && !wp) la = a;
    if (w) ld = hd;
    if (!w && wp && !pr) begin
      if (sq == 2'h0 && la == `PPW_CMD0_ADDR && ld == `PPW_CMD0_DATA) sq = 2'h1;
      else if (sq == 2'h1 && la == `PPW_CMD1_ADDR && ld == `PPW_CMD1_DATA) sq = 2'h2;
      else if (sq == 2'h2 && la == `PPW_CMD2_ADDR && ld == `PPW_CMD2_DATA) sq = 2'h3;
      else if (sq == 2'h3) begin
        if (!lo) pg = la[12:6];
        pb[la[5:0]] = ld;
        pm[la[5:0]] = 1'b1;
        lo = 1'b1;
        t = 0;
      end else begin
        pr = 1'b1;
        t = 0;
      end
    end
    if (r && !rp && lo) t = BLC;
    if (lo && t >= BLC) begin
      lo = 1'b0;
      pr = 1'b1;
      t = 0;
    end
    if (r && !rp) begin
      tg = tg ^ pr;
      rd = pr ? {mem[a][7], tg, mem[a][5:0]} : mem[a];
    end
    if (!r && rp) lst = rd;
    if (pr && t >= (slow ? 5 * WC : WC)) begin
      for (i = 0; i < 64; i = i + 1) if (pm[i]) mem[{pg, i[5:0]}] = pb[i];
      pm = 0;
      pr = 1'b0;
      sq = 2'h0;
    end
    wp = w;
    rp = r;
  end
endmodule

// ===== verif/tb_ppw_host.sv
// Self-checking bench for the page write host
`timescale 1ns/1ps
module tb_ppw_host;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg start = 1'b0;
  reg slow = 1'b0;
  reg wr_valid = 1'b0;
  reg [12:0] sa = 13'h0000;
  reg [6:0] bc = 7'h00;
  reg [7:0] wd = 8'h00;
  wire busy, done_r, timeout_r, wr_ready, ce_n, oe_n, we_n, doe;
  wire [12:0] ma;
  wire [7:0] dqo, dqi;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer i;
  reg [7:0] em [0:8191];
  always #4 clk = ~clk;
  // Host window kept well inside the model's load window
  ppw_host #(.BLC_CYC(120), .WC_CYC(2000)) dut (.clk(clk), .rst_n(rst_n), .start(start), .start_addr(sa),
    .byte_count(bc), .busy(busy), .done_r(done_r), .timeout_r(timeout_r), .wr_data(wd), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .mem_addr_r(ma), .mem_ce_n_r(ce_n), .mem_oe_n_r(oe_n), .mem_we_n_r(we_n),
    .mem_dq_out_r(dqo), .mem_dq_oe_r(doe), .mem_dq_in(dqi));
  ppw_mem_model #(.BLC(150), .WC(600)) mdl (.clk(clk), .slow(slow), .a(ma), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .hd(dqo), .hoe(doe), .dq(dqi));
  task results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input [31:0] nm, input [7:0] e, input [7:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %0s exp %h got %h", nm, e, g);
    end
  endtask
  task waitsig(input integer which);
    integer k;
    k = 0;
    @(negedge clk);
    while ((which ? done_r : wr_ready) !== 1'b1) begin
      k = k + 1;
      if (k > 20000) begin
        error_cnt = error_cnt + 1;
        results;
      end
      @(negedge clk);
    end
  endtask
  task page(input [12:0] a, input integer n, input s, input integer g);
    integer j;
    reg [7:0] d;
    @(posedge clk);
    slow <= s;
    sa <= a;
    bc <= n[6:0];
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (j = 0; j < n; j = j + 1) begin
      // Stall the stream so the load window lapses mid page
      if (j == g) begin
        wr_valid <= 1'b0;
        repeat (2000) @(posedge clk);
      end
      d = 8'($urandom);
      em[{a[12:6], a[5:0] + j[5:0]}] = d;
      wd <= d;
      wr_valid <= 1'b1;
      waitsig(0);
      @(posedge clk);
    end
    wr_valid <= 1'b0;
    waitsig(1);
    chk("tout", {7'h00, s}, {7'h00, timeout_r});
    @(negedge clk);
    chk("busy", 8'h00, {7'h00, busy});
    if (!s) for (j = 0; j < 64; j = j + 1) chk("mem", em[{a[12:6], j[5:0]}], mdl.mem[{a[12:6], j[5:0]}]);
    $display("test %h %0d done", a, n);
  endtask
  initial begin
    for (i = 0; i < 8192; i = i + 1) em[i] = 8'hFF;
    i = $urandom(84);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    page(13'h1553, 4, 1'b0, 99);
    page(13'h0A3E, 64, 1'b0, 99);
    chk("cmd", 8'hFF, mdl.mem[13'h0AAA]);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk);
      bc <= i ? 7'h41 : 7'h00;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(negedge clk);
      chk("busy", 8'h00, {7'h00, busy});
    end
    $display("test refused starts done");
    page(13'($urandom), 1 + $urandom % 64, 1'b0, 99);
    page(13'h1A40, 40, 1'b0, 36);
    page(13'h0500, 2, 1'b1, 99);
    results;
  end
endmodule
